// ===== tb/tb.sv
// bench for zone_speed_sequence_monitor with the scanner model
// assumes the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys = 0;
	logic        reset_n = 0;
	logic [1:0]  zone = 0;
	logic        manualMode = 0, enablingDevice = 0, resetButton = 0, restartButton = 0;
	logic        regWrite = 0, regRead = 0;
	logic [2:0]  regAddr = 0;
	logic [31:0] regWdata = 0;
	wire         slowdownZoneField, stopZoneField, reducedSpeedCheck, stopCheck;
	wire         motionPermit, seqError, irq;
	wire  [31:0] regRdata;
	int          mismatches = 0, n_compared = 0;
	always #2 clk_sys = ~clk_sys;
	zone_field_model scan (.zone, .slowdownZoneField, .stopZoneField);
	zone_speed_sequence_monitor dut (.clk_sys, .reset_n, .slowdownZoneField, .stopZoneField,
		.manualMode, .enablingDevice, .resetButton, .restartButton, .reducedSpeedCheck,
		.stopCheck, .motionPermit, .seqError, .regAddr, .regWdata, .regWrite, .regRead,
		.regRdata, .irq);
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic setZone(logic [1:0] z);
		@(posedge clk_sys);
		zone <= z;
		step(2);
	endtask
	// b: bit1 reset button, bit0 restart button
	task automatic press(logic [1:0] b);
		@(posedge clk_sys);
		{resetButton, restartButton} <= b;
		@(posedge clk_sys);
		{resetButton, restartButton} <= 2'h0;
		step(2);
	endtask
	task automatic wr(logic [2:0] a, logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge clk_sys);
		regWrite <= 1'h0;
		step(1);
	endtask
	task automatic rd(logic [2:0] a, logic [31:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge clk_sys);
		regRead <= 1'h0;
		#1;
		chk("regRdata", exp, regRdata);
	endtask
	task automatic scErrorClear();
		chk("seqError", 1'h1, seqError);
		setZone(2'h1);
		press(2'h2);
		chk("seqError", 1'h1, seqError);
		setZone(2'h0);
		press(2'h2);
		chk("motionPermit", 1'h1, motionPermit);
	endtask
	task automatic scValid();
		setZone(2'h1);
		chk("reducedSpeedCheck", 1'h1, reducedSpeedCheck);
		chk("motionPermit", 1'h1, motionPermit);
		setZone(2'h3);
		chk("stopCheck", 1'h1, stopCheck);
		chk("motionPermit", 1'h0, motionPermit);
		setZone(2'h1);
		chk("motionPermit", 1'h0, motionPermit);
		setZone(2'h0);
		chk("motionPermit", 1'h1, motionPermit);
	endtask
	task automatic scSeqErr();
		setZone(2'h2);
		chk("seqError", 1'h1, seqError);
		chk("motionPermit", 1'h0, motionPermit);
		setZone(2'h0);
		press(2'h1);
		chk("motionPermit", 1'h0, motionPermit);
		press(2'h2);
		chk("motionPermit", 1'h1, motionPermit);
	endtask
	task automatic scManual();
		@(posedge clk_sys);
		manualMode <= 1'h1;
		enablingDevice <= 1'h1;
		setZone(2'h2);
		chk("motionPermit", 1'h1, motionPermit);
		setZone(2'h1);
		chk("motionPermit", 1'h1, motionPermit);
		setZone(2'h0);
		@(posedge clk_sys);
		manualMode <= 1'h0;
		enablingDevice <= 1'h0;
		step(2);
		chk("motionPermit", 1'h0, motionPermit);
		press(2'h1);
		chk("motionPermit", 1'h1, motionPermit);
	endtask
	// irq events are cleared first so earlier scenarios leave no trace
	task automatic scIrq();
		wr(3'h2, 32'hF);
		wr(3'h3, 32'h0);
		rd(3'h2, 32'h0);
		setZone(2'h1);
		setZone(2'h0);
		chk("irq", 1'h0, irq);
		wr(3'h3, 32'h2);
		chk("irq", 1'h1, irq);
		wr(3'h2, 32'hF);
		chk("irq", 1'h0, irq);
		rd(3'h2, 32'h0);
		rd(3'h0, 32'h0);
		rd(3'h5, 32'h0);
	endtask
	// sequence error seen through irq and status, cleared by the software reset bit
	task automatic scSwReset();
		wr(3'h3, 32'hF);
		wr(3'h2, 32'hF);
		setZone(2'h2);
		chk("irq", 1'h1, irq);
		rd(3'h2, 32'h5);
		rd(3'h1, 32'h8000_0028);
		setZone(2'h0);
		chk("seqError", 1'h1, seqError);
		wr(3'h0, 32'h2);
		chk("seqError", 1'h0, seqError);
		chk("motionPermit", 1'h1, motionPermit);
		wr(3'h2, 32'hF);
		chk("irq", 1'h0, irq);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'h1;
		step(1);
		scErrorClear();
		scValid();
		scSeqErr();
		scManual();
		scIrq();
		scSwReset();
		conclude();
	end
	initial begin
		repeat (2000) @(posedge clk_sys);
		mismatches++;
		conclude();
	end
endmodule
bind zone_speed_sequence_monitor zone_speed_sva sva (.clk_sys, .reset_n, .slowdownZoneField,
	.stopZoneField, .manualMode, .enablingDevice, .reducedSpeedCheck, .stopCheck,
	.motionPermit, .seqError);
`default_nettype wire

// ===== tb/zone_field_model.sv
// scanner model: zone code to the two protective field levels
// assumes the bench changes the code just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module zone_field_model (
	// zone code: bit0 slowdown, bit1 stop
	input  wire logic [1:0] zone,
	// field levels, high while interrupted
	output wire logic       slowdownZoneField,
	output wire logic       stopZoneField
);
	assign slowdownZoneField = zone[0];
	assign stopZoneField     = zone[1];
endmodule
`default_nettype wire

// ===== tb/zone_speed_sva.sv
// checker on the monitor ports
// assumes the manual bit of the control register stays clear
`timescale 1ns/1ps
`default_nettype none
module zone_speed_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// fields and operator inputs
	input wire logic slowdownZoneField,
	input wire logic stopZoneField,
	input wire logic manualMode,
	input wire logic enablingDevice,
	// requests to the robot
	input wire logic reducedSpeedCheck,
	input wire logic stopCheck,
	input wire logic motionPermit,
	input wire logic seqError
);
	wire enab = manualMode && enablingDevice;
	wire autoMode = !manualMode;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	stop_check_a: assert property (stopZoneField |=> stopCheck)
		else $error("stop check late");
	slow_check_a: assert property (slowdownZoneField |=> reducedSpeedCheck)
		else $error("slow check late");
	auto_stop_a: assert property (autoMode && stopZoneField |=> !motionPermit)
		else $error("auto stop missing");
	manual_stop_a: assert property (enab && stopZoneField ##1 enab |=> motionPermit)
		else $error("manual motion blocked");
	manual_slow_a: assert property (enab && slowdownZoneField ##1 enab |=> motionPermit)
		else $error("manual motion blocked");
	seq_err_a: assert property (autoMode && $rose(stopZoneField) && !reducedSpeedCheck
		&& !slowdownZoneField |=> seqError) else $error("sequence error missed");
	err_hold_a: assert property (seqError && (slowdownZoneField || stopZoneField)
		|=> seqError) else $error("error left early");
	restart_a: assert property (autoMode && $fell(slowdownZoneField) && !stopZoneField
		&& !stopCheck && !seqError |=> motionPermit) else $error("no restart");
	cover property (motionPermit ##1 !motionPermit);
	cover property ($fell(seqError));
	cover property (manualMode && stopZoneField && motionPermit);
endmodule
`default_nettype wire

// ===== verilog/edge_rise.v
// rising edge detector for a synchronous level
// assumes input already in clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module edge_rise (
	// clock and reset
	input  wire clk_sys,
	input  wire reset_n,
	// level in, pulse out
	input  wire level,
	output wire pulse
);
	reg levelQ;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			levelQ <= 1'b0;
		else
			levelQ <= level;
	end

	assign pulse = level & ~levelQ;
endmodule
`default_nettype wire

// ===== verilog/sticky_flag.v
// sticky event bit, cleared by write-one, set wins over clear
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
	// clock and reset
	input  wire clk_sys,
	input  wire reset_n,
	// event and clear
	input  wire setEvt,
	input  wire clrReq,
	output reg  flag_q
);
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			flag_q <= 1'b0;
		else if (setEvt)
			flag_q <= 1'b1;
		else if (clrReq)
			flag_q <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== verilog/zone_speed_defs.vh
// constants for the zone speed sequence monitor
// assumes one synchronous clock domain, inputs already synchronous
//
// Behaviour
// - automated mode: stop zone interrupted commands stop
// - stop zone interrupted drives stop check safe
// - automated mode: slowdown zone requests reduced speed
// - slowdown zone interrupted drives reduced check safe
// - manual mode: enabling device permits motion, stop zone
// - manual mode: enabling device permits motion, slowdown zone
// - valid sequence restarts automatically when slowdown frees
// - stop zone always stops in automated mode
// - stop without prior slowdown is sequence error
// - error cleared only when fields free plus reset
`ifndef ZONE_SPEED_DEFS_VH
`define ZONE_SPEED_DEFS_VH

// register indices
`define REG_CTRL     3'h0
`define REG_STATUS   3'h1
`define REG_IRQ_STAT 3'h2
`define REG_IRQ_MASK 3'h3

// control fields
`define CTRL_WIDTH     2
`define CTRL_RESET_VAL 2'h0
`define CTRL_MANUAL    0
`define CTRL_SWRESET   1

// interrupt event bits
`define EVT_WIDTH   4
`define EVT_STOP    0
`define EVT_SLOW    1
`define EVT_SEQERR  2
`define EVT_RESTART 3

// sequence states
`define ST_RUN    3'h0
`define ST_SLOW   3'h1
`define ST_STOP   3'h2
`define ST_AFTER  3'h3
`define ST_ERROR  3'h4

`endif

// ===== verilog/zone_speed_sequence_monitor.v
// zone speed sequence monitor: scanner fields to speed-check requests
// assumes field, button and mode inputs synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "zone_speed_defs.vh"
module zone_speed_sequence_monitor (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset_n,
	// scanner fields, high while interrupted
	input  wire        slowdownZoneField,
	input  wire        stopZoneField,
	// operator inputs
	input  wire        manualMode,
	input  wire        enablingDevice,
	input  wire        resetButton,
	input  wire        restartButton,
	// requests to robot, checks high = safe state requested, motionPermit high = motion allowed
	output reg         reducedSpeedCheck,
	output reg         stopCheck,
	output reg         motionPermit,
	output reg         seqError,
	// register port
	input  wire [2:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [31:0] regRdata,
	// interrupt
	output wire        irq
);
	reg  [`CTRL_WIDTH-1:0] ctrl_q;
	reg  [`EVT_WIDTH-1:0]  mask_q;
	reg  [2:0]             state_q;
	reg  [2:0]             state_d;
	reg                    manualSeen_q;
	wire [`EVT_WIDTH-1:0]  evt;
	wire [`EVT_WIDTH-1:0]  stat;
	wire [`EVT_WIDTH-1:0]  clr;
	wire                   resetPulse;
	wire                   restartPulse;
	wire                   stopRise;
	wire                   slowRise;
	wire                   manualEff;
	wire                   anyField;
	wire                   resetReq;

	assign manualEff = manualMode | ctrl_q[`CTRL_MANUAL];
	assign anyField  = slowdownZoneField | stopZoneField;

	edge_rise uReset (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.level   (resetButton),
		.pulse   (resetPulse)
	);
	edge_rise uRestart (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.level   (restartButton),
		.pulse   (restartPulse)
	);
	edge_rise uStop (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.level   (stopZoneField),
		.pulse   (stopRise)
	);
	edge_rise uSlow (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.level   (slowdownZoneField),
		.pulse   (slowRise)
	);

	// software may stand in for the pushbutton; same all-free condition
	assign resetReq = resetPulse | (regWrite && regAddr == `REG_CTRL && regWdata[`CTRL_SWRESET]);

	// manual mode only blocks leaving RUN (to ERROR or SLOW) and SLOW to STOP; the other transitions still follow the fields
	always @* begin
		state_d = state_q;
		case (state_q)
			`ST_RUN: begin
				if (!manualEff && stopZoneField)
					state_d = `ST_ERROR;
				else if (!manualEff && slowdownZoneField)
					state_d = `ST_SLOW;
			end
			`ST_SLOW: begin
				if (!manualEff && stopZoneField)
					state_d = `ST_STOP;
				else if (!slowdownZoneField)
					state_d = `ST_RUN;
			end
			`ST_STOP: begin
				// stop zone must clear while slowdown still held
				if (!stopZoneField && slowdownZoneField)
					state_d = `ST_AFTER;
				else if (!stopZoneField)
					state_d = `ST_ERROR;
			end
			`ST_AFTER: begin
				if (stopZoneField)
					state_d = `ST_STOP;
				else if (!slowdownZoneField)
					state_d = `ST_RUN;
			end
			`ST_ERROR: begin
				if (resetReq && !anyField)
					state_d = `ST_RUN;
			end
			default: state_d = `ST_ERROR;
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			state_q <= `ST_ERROR;
		else
			state_q <= state_d;
	end

	// restart after manual operation needs the restart button
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			manualSeen_q <= 1'b0;
		else if (manualEff)
			manualSeen_q <= 1'b1;
		else if (restartPulse)
			manualSeen_q <= 1'b0;
	end

	// outputs registered; stop check goes safe on any stop-zone interruption
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stopCheck         <= 1'b1;
			reducedSpeedCheck <= 1'b1;
			motionPermit      <= 1'b0;
			seqError          <= 1'b1;
		end else begin
			stopCheck         <= stopZoneField;
			reducedSpeedCheck <= slowdownZoneField;
			seqError          <= (state_d == `ST_ERROR);
			if (manualEff)
				motionPermit <= enablingDevice;
			else
				motionPermit <= !stopZoneField && !manualSeen_q
					&& (state_d != `ST_ERROR) && (state_d != `ST_STOP)
					&& (state_d != `ST_AFTER);
		end
	end
	// slowdown in automated mode keeps motion but at reduced speed

	assign evt[`EVT_STOP]    = stopRise & ~manualEff;
	assign evt[`EVT_SLOW]    = slowRise & ~manualEff;
	assign evt[`EVT_SEQERR]  = (state_d == `ST_ERROR) && (state_q != `ST_ERROR);
	assign evt[`EVT_RESTART] = (state_q == `ST_AFTER) && (state_d == `ST_RUN);

	genvar gi;
	generate
		for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1) begin : gFlag
			assign clr[gi] = regWrite && regAddr == `REG_IRQ_STAT && regWdata[gi];
			sticky_flag uFlag (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.setEvt  (evt[gi]),
				.clrReq  (clr[gi]),
				.flag_q  (stat[gi])
			);
		end
	endgenerate

	assign irq = |(stat & mask_q);

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `CTRL_RESET_VAL;
			mask_q <= {`EVT_WIDTH{1'b0}};
		end else if (regWrite) begin
			if (regAddr == `REG_CTRL)
				ctrl_q <= {1'b0, regWdata[`CTRL_MANUAL]};
			if (regAddr == `REG_IRQ_MASK)
				mask_q <= regWdata[`EVT_WIDTH-1:0];
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			regRdata <= 32'h0000_0000;
		else if (regRead) begin
			case (regAddr)
				`REG_CTRL:     regRdata <= {30'h0, ctrl_q};
				`REG_STATUS:   regRdata <= {26'h0, seqError, motionPermit,
					stopCheck, reducedSpeedCheck, manualEff, manualSeen_q} |
					{state_q, 29'h0};
				`REG_IRQ_STAT: regRdata <= {28'h0, stat};
				`REG_IRQ_MASK: regRdata <= {28'h0, mask_q};
				default:       regRdata <= 32'h0000_0000;
			endcase
		end else
			regRdata <= 32'h0000_0000;
	end
endmodule
`default_nettype wire
